// File: logic/bfs_regs.vh
// bfs_regs.vh: register map, field positions, reset values and timing
// constants of the breaker failure supervisor.
// assumes inclusion by bare name from the design file only.
`ifndef BFS_REGS_VH
`define BFS_REGS_VH

// word addresses on the avalon word address bus (address is byte offset >> 2)
`define BFS_ADDR_CTRL 4'h0
`define BFS_ADDR_FAILDLY 4'h1
`define BFS_ADDR_RETRIPDLY 4'h2
`define BFS_ADDR_NLDDLY 4'h3
`define BFS_ADDR_PHPICK 4'h4
`define BFS_ADDR_GNDPICK 4'h5
`define BFS_ADDR_STATUS 4'h6
`define BFS_ADDR_IRQ_STAT 4'h7
`define BFS_ADDR_IRQ_MASK 4'h8

// ctrl fields
`define BFS_CTRL_ENABLE 0
`define BFS_CTRL_RETRIP_EN 1
`define BFS_CTRL_NLOAD_EN 2
`define BFS_CTRL_EXT_ASSIGNED 3
`define BFS_CTRL_NLD_ASSIGNED 4
`define BFS_CTRL_ENIN_ASSIGNED 5
`define BFS_CTRL_W 6
`define BFS_CTRL_RST 6'h00

// delay settings in steps of 10 ms, 0..200
`define BFS_DLY_W 8
`define BFS_DLY_MAX 8'hC8
`define BFS_DLY_RST 8'h00

// current samples and pickups, unsigned magnitude
`define BFS_CUR_W 16
`define BFS_PICK_RST 16'h0000

// status / interrupt bits
`define BFS_EV_W 4
`define BFS_EV_PICKUP 0
`define BFS_EV_RETRIP 1
`define BFS_EV_OPERATE 2
`define BFS_EV_NLOAD 3

// consecutive low samples that drop current detection
`define BFS_LOW_SAMPLES 2'h3

// one delay step is 10 ms at a 100 MHz clock
`define BFS_STEP_NS 10000000
`define BFS_CLK_NS 10
`define BFS_TICK_W 20

// positions of the synchronised pin inputs
`define BFS_PIN_W 5
`define BFS_PIN_TRIP 0
`define BFS_PIN_EXT 1
`define BFS_PIN_NLD 2
`define BFS_PIN_BRK 3
`define BFS_PIN_UEN 4

// width of the read-only status word
`define BFS_STAT_W 8

`endif

// File: logic/bfs_top.v
// bfs_top.v: breaker failure supervisor with avalon-mm settings registers.
// assumes one 100 MHz clock; trip, contact and enable lines come from
// pins and are synchronised here; samples arrive with a same-clock strobe.
//
// Contract
// - failure initiate is set whenever internal trip or external trip is on.
// - the failure timer runs while initiate and current detection both hold.
// - the failure output rises when the failure timer reaches its delay.
// - losing initiate or current detection clears the failure timer at once.
// - the retrip timer starts with the failure timer and retrip fires first; here the order follows the two delay settings, equal delays fire together.
// - the no-load timer runs while no-load initiate is on and breaker closed.
// - no-load timer expiry raises the failure output regardless of current.
// - a no-load pickup also drives the retrip timer and retrip output.
// - current detection is on while any phase or ground sample is above pickup.
// - current detection drops after three consecutive samples all below pickup.
// - an unassigned external trip input reads as logic zero.
// - an unassigned no-load initiate input reads as logic zero.
// - the failure delay is 0 to 2.00 s in 10 ms steps, default zero.
// - retrip and no-load delays share that range and step, default zero.
// - the enable input puts the unit in service and defaults to one.
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`default_nettype none
`include "bfs_regs.vh"

module bfs_top (
    input wire CLK_SYS_I,
    input wire SRST_I,
    input wire [3:0] AVS_ADDRESS_I,
    input wire AVS_READ_I,
    input wire AVS_WRITE_I,
    input wire [31:0] AVS_WRITEDATA_I,
    output reg [31:0] AVS_READDATA_O,
    output reg AVS_WAITREQUEST_O,
    input wire TRIP_INT_I,
    input wire EXTERNAL_TRIP_IN_I,
    input wire NOLOAD_INITIATE_IN_I,
    input wire BREAKER_CLOSED_I,
    input wire UNIT_ENABLE_IN_I,
    input wire SAMPLE_VALID_I,
    input wire [15:0] SAMPLE_A_I,
    input wire [15:0] SAMPLE_B_I,
    input wire [15:0] SAMPLE_C_I,
    input wire [15:0] SAMPLE_G_I,
    output reg FAILURE_OPERATE_OUT_O,
    output reg REISSUE_TRIP_OUT_O,
    output reg UNIT_ENABLED_O,
    output reg CURRENT_PRESENT_O,
    output reg IRQ_O
);

// step length in clock cycles, cut to the tick counter width on purpose
localparam integer TICK_N = `BFS_STEP_NS / `BFS_CLK_NS - 1;
localparam [`BFS_TICK_W-1:0] TICK_LAST = TICK_N[`BFS_TICK_W-1:0];

reg [`BFS_CTRL_W-1:0] ctrl_reg;
reg [`BFS_DLY_W-1:0] fail_dly_reg;
reg [`BFS_DLY_W-1:0] retrip_dly_reg;
reg [`BFS_DLY_W-1:0] nld_dly_reg;
reg [`BFS_CUR_W-1:0] ph_pick_reg;
reg [`BFS_CUR_W-1:0] gnd_pick_reg;
reg [`BFS_EV_W-1:0] irq_stat_reg;
reg [`BFS_EV_W-1:0] irq_mask_reg;

// two-flop synchronisers for the five pin inputs; a trip pin may move at
// any instant, so only the second stage is ever read by logic
wire [`BFS_PIN_W-1:0] pin_raw;
assign pin_raw[`BFS_PIN_TRIP] = TRIP_INT_I;
assign pin_raw[`BFS_PIN_EXT] = EXTERNAL_TRIP_IN_I;
assign pin_raw[`BFS_PIN_NLD] = NOLOAD_INITIATE_IN_I;
assign pin_raw[`BFS_PIN_BRK] = BREAKER_CLOSED_I;
assign pin_raw[`BFS_PIN_UEN] = UNIT_ENABLE_IN_I;
reg [`BFS_PIN_W-1:0] pin_meta_reg;
reg [`BFS_PIN_W-1:0] pin_sync_reg;

always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
        pin_meta_reg <= {`BFS_PIN_W{1'b0}};
        pin_sync_reg <= {`BFS_PIN_W{1'b0}};
    end else begin
        pin_meta_reg <= pin_raw;
        pin_sync_reg <= pin_meta_reg;
    end
end

// an input that no pin is assigned to reads as its default level
wire trip_int = pin_sync_reg[`BFS_PIN_TRIP];
wire external_trip_in = pin_sync_reg[`BFS_PIN_EXT] &
    ctrl_reg[`BFS_CTRL_EXT_ASSIGNED];
wire nld_init = pin_sync_reg[`BFS_PIN_NLD] &
    ctrl_reg[`BFS_CTRL_NLD_ASSIGNED];
wire brk_closed = pin_sync_reg[`BFS_PIN_BRK];
wire enable_in = ctrl_reg[`BFS_CTRL_ENIN_ASSIGNED] ?
    pin_sync_reg[`BFS_PIN_UEN] : 1'b1;
// every run term below is gated by this, so a disabled unit holds all
// timers at zero and both outputs low
wire in_service = ctrl_reg[`BFS_CTRL_ENABLE] & enable_in;

wire failure_initiate = trip_int | external_trip_in;

// current detector on instantaneous samples
wire [3:0] over_pick;
genvar gi;
generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_cmp
        wire [`BFS_CUR_W-1:0] smp = (gi == 0) ? SAMPLE_A_I :
            (gi == 1) ? SAMPLE_B_I : (gi == 2) ? SAMPLE_C_I : SAMPLE_G_I;
        wire [`BFS_CUR_W-1:0] pick = (gi == 3) ? gnd_pick_reg : ph_pick_reg;
        // strict compare: a sample equal to pickup counts as low
        assign over_pick[gi] = smp > pick;
    end
endgenerate

reg [1:0] low_cnt_reg;
reg cur_present_reg;

always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
        low_cnt_reg <= 2'h0;
        cur_present_reg <= 1'b0;
    end else if (SAMPLE_VALID_I) begin
        // any sample above pickup restarts the run of low samples
        if (|over_pick) begin
            low_cnt_reg <= 2'h0;
            cur_present_reg <= 1'b1;
        end else if (low_cnt_reg == `BFS_LOW_SAMPLES - 2'h1) begin
            // instantaneous check resets far faster than an rms average
            low_cnt_reg <= 2'h0;
            cur_present_reg <= 1'b0;
        end else begin
            low_cnt_reg <= low_cnt_reg + 2'h1;
        end
    end
end

// shared 10 ms step tick, free running
reg [`BFS_TICK_W-1:0] tick_cnt_reg;
wire step = (tick_cnt_reg == TICK_LAST);

always @(posedge CLK_SYS_I) begin
    if (SRST_I || step)
        tick_cnt_reg <= {`BFS_TICK_W{1'b0}};
    else
        tick_cnt_reg <= tick_cnt_reg + 1'b1;
end

wire fail_run = in_service & failure_initiate & cur_present_reg;
wire nld_run = in_service & ctrl_reg[`BFS_CTRL_NLOAD_EN] &
    nld_init & brk_closed;
wire rt_run = in_service & ctrl_reg[`BFS_CTRL_RETRIP_EN] &
    (fail_run | nld_run);

reg [`BFS_DLY_W-1:0] fail_tmr_reg;
reg [`BFS_DLY_W-1:0] nld_tmr_reg;
reg [`BFS_DLY_W-1:0] rt_tmr_reg;
wire fail_done = fail_run && (fail_tmr_reg >= fail_dly_reg);
wire nld_done = nld_run && (nld_tmr_reg >= nld_dly_reg);
wire rt_done = rt_run && (rt_tmr_reg >= retrip_dly_reg);

// a timer counts 10 ms steps only while its run condition holds; a short
// first step of up to 10 ms is the price of sharing one prescaler;
// counting stops at the setting so a long fault cannot wrap the timer
always @(posedge CLK_SYS_I) begin
    if (SRST_I || !fail_run)
        fail_tmr_reg <= `BFS_DLY_RST;
    else if (step && !fail_done)
        fail_tmr_reg <= fail_tmr_reg + 1'b1;
end

always @(posedge CLK_SYS_I) begin
    if (SRST_I || !nld_run)
        nld_tmr_reg <= `BFS_DLY_RST;
    else if (step && !nld_done)
        nld_tmr_reg <= nld_tmr_reg + 1'b1;
end

always @(posedge CLK_SYS_I) begin
    if (SRST_I || !rt_run)
        rt_tmr_reg <= `BFS_DLY_RST;
    else if (step && !rt_done)
        rt_tmr_reg <= rt_tmr_reg + 1'b1;
end

// events: pickup, retrip, operate, no-load pickup (rising edges)
// a condition that stays up is logged once, not on every cycle
reg fail_run_d_reg;
reg nld_run_d_reg;
wire [`BFS_EV_W-1:0] ev;
assign ev[`BFS_EV_PICKUP] = fail_run & ~fail_run_d_reg;
assign ev[`BFS_EV_RETRIP] = rt_done & ~REISSUE_TRIP_OUT_O;
assign ev[`BFS_EV_OPERATE] = (fail_done | nld_done) & ~FAILURE_OPERATE_OUT_O;
assign ev[`BFS_EV_NLOAD] = nld_run & ~nld_run_d_reg;

// a write lands only on the edge that completes the transfer, where
// waitrequest is low; read data is loaded one edge earlier, while
// waitrequest is still high, so that it stands on that same edge
wire bus_wr = AVS_WRITE_I & ~AVS_WAITREQUEST_O;
wire bus_rd = AVS_READ_I & AVS_WAITREQUEST_O;

// clamp delays to the 2.00 s top of range
function [`BFS_DLY_W-1:0] clamp_dly;
    input [31:0] d;
    begin
        if (d[`BFS_DLY_W-1:0] > `BFS_DLY_MAX || |d[31:`BFS_DLY_W])
            clamp_dly = `BFS_DLY_MAX;
        else
            clamp_dly = d[`BFS_DLY_W-1:0];
    end
endfunction

always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
        ctrl_reg <= `BFS_CTRL_RST;
        fail_dly_reg <= `BFS_DLY_RST;
        retrip_dly_reg <= `BFS_DLY_RST;
        nld_dly_reg <= `BFS_DLY_RST;
        ph_pick_reg <= `BFS_PICK_RST;
        gnd_pick_reg <= `BFS_PICK_RST;
        irq_mask_reg <= {`BFS_EV_W{1'b0}};
    end else if (bus_wr) begin
        if (AVS_ADDRESS_I == `BFS_ADDR_CTRL)
            ctrl_reg <= AVS_WRITEDATA_I[`BFS_CTRL_W-1:0];
        else if (AVS_ADDRESS_I == `BFS_ADDR_FAILDLY)
            fail_dly_reg <= clamp_dly(AVS_WRITEDATA_I);
        else if (AVS_ADDRESS_I == `BFS_ADDR_RETRIPDLY)
            retrip_dly_reg <= clamp_dly(AVS_WRITEDATA_I);
        else if (AVS_ADDRESS_I == `BFS_ADDR_NLDDLY)
            nld_dly_reg <= clamp_dly(AVS_WRITEDATA_I);
        else if (AVS_ADDRESS_I == `BFS_ADDR_PHPICK)
            ph_pick_reg <= AVS_WRITEDATA_I[`BFS_CUR_W-1:0];
        else if (AVS_ADDRESS_I == `BFS_ADDR_GNDPICK)
            gnd_pick_reg <= AVS_WRITEDATA_I[`BFS_CUR_W-1:0];
        else if (AVS_ADDRESS_I == `BFS_ADDR_IRQ_MASK)
            irq_mask_reg <= AVS_WRITEDATA_I[`BFS_EV_W-1:0];
    end
end

// write-one-to-clear; a new event in the same cycle wins over the clear
wire [`BFS_EV_W-1:0] w1c = (bus_wr && AVS_ADDRESS_I == `BFS_ADDR_IRQ_STAT) ?
    AVS_WRITEDATA_I[`BFS_EV_W-1:0] : {`BFS_EV_W{1'b0}};

always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
        irq_stat_reg <= {`BFS_EV_W{1'b0}};
        fail_run_d_reg <= 1'b0;
        nld_run_d_reg <= 1'b0;
        FAILURE_OPERATE_OUT_O <= 1'b0;
        REISSUE_TRIP_OUT_O <= 1'b0;
        UNIT_ENABLED_O <= 1'b0;
        CURRENT_PRESENT_O <= 1'b0;
        IRQ_O <= 1'b0;
    end else begin
        irq_stat_reg <= (irq_stat_reg & ~w1c) | ev;
        fail_run_d_reg <= fail_run;
        nld_run_d_reg <= nld_run;
        FAILURE_OPERATE_OUT_O <= fail_done | nld_done;
        REISSUE_TRIP_OUT_O <= rt_done;
        UNIT_ENABLED_O <= in_service;
        CURRENT_PRESENT_O <= cur_present_reg;
        IRQ_O <= |(((irq_stat_reg & ~w1c) | ev) & irq_mask_reg);
    end
end

// live snapshot for the read-only status register
wire [`BFS_STAT_W-1:0] status_word = {in_service, cur_present_reg,
    failure_initiate, nld_run, rt_done, fail_done | nld_done,
    fail_run, rt_run};

// avalon slave: one wait state, answer on the second edge of a request
always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
        AVS_WAITREQUEST_O <= 1'b1;
        AVS_READDATA_O <= 32'h00000000;
    end else begin
        AVS_WAITREQUEST_O <= ~((AVS_READ_I | AVS_WRITE_I) &
            AVS_WAITREQUEST_O);
        if (bus_rd) begin
            if (AVS_ADDRESS_I == `BFS_ADDR_CTRL)
                AVS_READDATA_O <= {26'h0, ctrl_reg};
            else if (AVS_ADDRESS_I == `BFS_ADDR_FAILDLY)
                AVS_READDATA_O <= {24'h0, fail_dly_reg};
            else if (AVS_ADDRESS_I == `BFS_ADDR_RETRIPDLY)
                AVS_READDATA_O <= {24'h0, retrip_dly_reg};
            else if (AVS_ADDRESS_I == `BFS_ADDR_NLDDLY)
                AVS_READDATA_O <= {24'h0, nld_dly_reg};
            else if (AVS_ADDRESS_I == `BFS_ADDR_PHPICK)
                AVS_READDATA_O <= {16'h0, ph_pick_reg};
            else if (AVS_ADDRESS_I == `BFS_ADDR_GNDPICK)
                AVS_READDATA_O <= {16'h0, gnd_pick_reg};
            else if (AVS_ADDRESS_I == `BFS_ADDR_STATUS)
                AVS_READDATA_O <= {24'h0, status_word};
            else if (AVS_ADDRESS_I == `BFS_ADDR_IRQ_STAT)
                AVS_READDATA_O <= {28'h0, irq_stat_reg};
            else if (AVS_ADDRESS_I == `BFS_ADDR_IRQ_MASK)
                AVS_READDATA_O <= {28'h0, irq_mask_reg};
            else
                AVS_READDATA_O <= 32'h00000000;
        end
    end
end

endmodule
`default_nettype wire

// File: test/bfs_far.sv
// bfs_far.sv: behavioural sampling front end feeding the supervisor.
// assumes the bench sets the phase and ground magnitudes to be seen.
`default_nettype none
module bfs_far (
    input wire logic clk_i,
    input wire logic [15:0] ph_i,
    input wire logic [15:0] gd_i,
    output logic valid_o,
    output logic [15:0] a_o,
    output logic [15:0] b_o,
    output logic [15:0] c_o,
    output logic [15:0] g_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_reg = 2'h0;
    always @(posedge clk_i) div_reg <= div_reg + 2'h1;
    assign valid_o = (div_reg == 2'h3);
    // off the strobe the lines carry junk, so a lax sampler is caught
    assign a_o = valid_o ? 16'h0000 : 16'hFFFF;
    assign c_o = a_o;
    assign b_o = valid_o ? ph_i : ~ph_i;
    assign g_o = valid_o ? gd_i : ~gd_i;
endmodule
`default_nettype wire

// File: test/bfs_top_checker.sv
// bfs_top_checker.sv: port-level assertions for the supervisor top.
// assumes it is bound to bfs_top, which has one clock domain.
`default_nettype none
module bfs_chk (
    input wire logic CLK_SYS_I,
    input wire logic SRST_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic AVS_WAITREQUEST_O,
    input wire logic TRIP_INT_I,
    input wire logic EXTERNAL_TRIP_IN_I,
    input wire logic NOLOAD_INITIATE_IN_I,
    input wire logic SAMPLE_VALID_I,
    input wire logic FAILURE_OPERATE_OUT_O,
    input wire logic REISSUE_TRIP_OUT_O,
    input wire logic UNIT_ENABLED_O,
    input wire logic CURRENT_PRESENT_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (SRST_I);
    wire rq = AVS_READ_I || AVS_WRITE_I;
    chk_one_wait: assert property (rq && AVS_WAITREQUEST_O
        |=> !AVS_WAITREQUEST_O) else $error("bus answer late");
    chk_wait_back: assert property (!AVS_WAITREQUEST_O
        |=> AVS_WAITREQUEST_O) else $error("wait low too long");
    chk_idle_wait: assert property (!rq |=> AVS_WAITREQUEST_O)
        else $error("wait low while idle");
    chk_cur_cause: assert property (
        $changed(CURRENT_PRESENT_O) && UNIT_ENABLED_O
        && $past(UNIT_ENABLED_O, 4) |-> $past(SAMPLE_VALID_I)
        || $past(SAMPLE_VALID_I, 2) || $past(SAMPLE_VALID_I, 3))
        else $error("current flag moved without a sample");
    chk_off_quiet: assert property (!UNIT_ENABLED_O [*3]
        |-> !FAILURE_OPERATE_OUT_O && !REISSUE_TRIP_OUT_O)
        else $error("output while out of service");
    chk_cur_gone: assert property (
        $fell(CURRENT_PRESENT_O) && !NOLOAD_INITIATE_IN_I
        |-> ##[0:3] !FAILURE_OPERATE_OUT_O)
        else $error("operate kept after current loss");
    chk_trip_gone: assert property (
        $fell(TRIP_INT_I) && !EXTERNAL_TRIP_IN_I
        && !NOLOAD_INITIATE_IN_I |-> ##[1:8] !FAILURE_OPERATE_OUT_O)
        else $error("operate kept after trip loss");
    chk_op_cause: assert property ($rose(FAILURE_OPERATE_OUT_O)
        |-> TRIP_INT_I || EXTERNAL_TRIP_IN_I || NOLOAD_INITIATE_IN_I)
        else $error("operate without initiate");
    chk_rt_live: assert property ($rose(REISSUE_TRIP_OUT_O)
        |-> UNIT_ENABLED_O) else $error("retrip while disabled");
endmodule
`default_nettype wire

// File: test/tb_breaker_failure_supervisor.sv
// tb_breaker_failure_supervisor.sv: self-checking bench, one task a case.
// assumes bfs_top, bfs_far and bfs_chk are compiled before this file.
`default_nettype none
module tb_breaker_failure_supervisor;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, rd_s = 0, wr_s = 0, trip = 0, ext = 0;
    logic nld = 0, brk = 1, enp = 0;
    logic [3:0] adr = 0;
    logic [31:0] wd = 0, q;
    logic [15:0] aph = 0, agd = 0;
    wire [31:0] rdat;
    wire wreq, fop, rtr, uen, cur, irq, sv;
    wire [15:0] sa, sb, sc, sg;
    int n_errors = 0, tests_run = 0, cyc = 0;
    always #5 clk = ~clk;
    bfs_far FAR(.clk_i(clk), .ph_i(aph), .gd_i(agd), .valid_o(sv),
        .a_o(sa), .b_o(sb), .c_o(sc), .g_o(sg));
    bfs_top DUT(.CLK_SYS_I(clk), .SRST_I(rst), .AVS_ADDRESS_I(adr),
        .AVS_READ_I(rd_s), .AVS_WRITE_I(wr_s), .AVS_WRITEDATA_I(wd),
        .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
        .TRIP_INT_I(trip), .EXTERNAL_TRIP_IN_I(ext),
        .NOLOAD_INITIATE_IN_I(nld), .BREAKER_CLOSED_I(brk),
        .UNIT_ENABLE_IN_I(enp), .SAMPLE_VALID_I(sv), .SAMPLE_A_I(sa),
        .SAMPLE_B_I(sb), .SAMPLE_C_I(sc), .SAMPLE_G_I(sg),
        .FAILURE_OPERATE_OUT_O(fop), .REISSUE_TRIP_OUT_O(rtr),
        .UNIT_ENABLED_O(uen), .CURRENT_PRESENT_O(cur), .IRQ_O(irq));
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic hold(int n);
        repeat (n) @(posedge clk);
    endtask
    // request held until the edge that samples waitrequest low
    task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
        rd_s <= !w;
        wr_s <= w;
        adr <= a;
        wd <= d;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        q = rdat;
        rd_s <= 0;
        wr_s <= 0;
        @(posedge clk);
    endtask
    task automatic rdc(logic [3:0] a, logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk("register", e, q);
    endtask
    task automatic t_regs();
        rdc(4'h0, 32'h0);
        rdc(4'h1, 32'h0);
        rdc(4'h2, 32'h0);
        rdc(4'h3, 32'h0);
        bus(1'b1, 4'h1, 32'hFF);
        rdc(4'h1, 32'hC8);
        bus(1'b1, 4'h3, 32'hC9);
        rdc(4'h3, 32'hC8);
        bus(1'b1, 4'h2, 32'h100);
        rdc(4'h2, 32'hC8);
        rdc(4'h9, 32'h0);
        bus(1'b1, 4'h1, 32'h0);
        bus(1'b1, 4'h2, 32'h0);
        bus(1'b1, 4'h3, 32'h0);
        bus(1'b1, 4'h4, 32'h64);
        bus(1'b1, 4'h5, 32'h64);
        rdc(4'h4, 32'h64);
    endtask
    task automatic t_operate();
        bus(1'b1, 4'h8, 32'h4);
        bus(1'b1, 4'h0, 32'h1);
        aph <= 16'h00C8;
        hold(40);
        chk("cur", 32'h1, cur);
        trip <= 1'b1;
        hold(20);
        chk("fop", 32'h1, fop);
        chk("irq", 32'h1, irq);
        trip <= 1'b0;
        hold(20);
        chk("fop", 32'h0, fop);
        chk("irq", 32'h1, irq);
        bus(1'b1, 4'h7, 32'h4);
        hold(3);
        chk("irq", 32'h0, irq);
        aph <= 16'h0000;
        agd <= 16'h00C8;
        hold(40);
        chk("cur", 32'h1, cur);
    endtask
    task automatic t_drop();
        trip <= 1'b1;
        hold(20);
        chk("fop", 32'h1, fop);
        agd <= 16'h0064; // equal to pickup counts as low
        hold(6);
        chk("cur", 32'h1, cur);
        hold(20);
        chk("cur", 32'h0, cur);
        chk("fop", 32'h0, fop);
        trip <= 1'b0;
        agd <= 16'h00C8;
        hold(40);
    endtask
    task automatic t_retrip();
        bus(1'b1, 4'h0, 32'h3);
        bus(1'b1, 4'h1, 32'h1);
        trip <= 1'b1;
        hold(40);
        chk("rtr", 32'h1, rtr);
        chk("fop", 32'h0, fop);
        trip <= 1'b0;
        hold(20);
        chk("rtr", 32'h0, rtr);
        bus(1'b1, 4'h1, 32'h0);
    endtask
    task automatic t_ext();
        ext <= 1'b1;
        hold(40);
        chk("fop", 32'h0, fop);
        bus(1'b1, 4'h0, 32'hB);
        hold(40);
        chk("fop", 32'h1, fop);
        ext <= 1'b0;
        agd <= 16'h0000;
        hold(40);
    endtask
    task automatic t_nld();
        nld <= 1'b1;
        bus(1'b1, 4'h0, 32'h7);
        hold(40);
        chk("fop", 32'h0, fop);
        bus(1'b1, 4'h0, 32'h17);
        hold(40);
        chk("cur", 32'h0, cur);
        chk("fop", 32'h1, fop);
        chk("rtr", 32'h1, rtr);
        nld <= 1'b0;
        hold(20);
        brk <= 1'b0;
        nld <= 1'b1;
        hold(40);
        chk("fop", 32'h0, fop);
        nld <= 1'b0;
        brk <= 1'b1;
    endtask
    task automatic t_enable();
        bus(1'b1, 4'h0, 32'h1);
        hold(10);
        chk("uen", 32'h1, uen);
        bus(1'b1, 4'h0, 32'h21);
        agd <= 16'h00C8;
        trip <= 1'b1;
        hold(40);
        chk("uen", 32'h0, uen);
        chk("fop", 32'h0, fop);
        enp <= 1'b1;
        hold(40);
        chk("fop", 32'h1, fop);
        bus(1'b1, 4'h0, 32'h20);
        hold(10);
        chk("fop", 32'h0, fop);
        trip <= 1'b0;
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    initial begin
        hold(10);
        rst <= 0;
        hold(1);
        t_regs();
        t_operate();
        t_drop();
        t_retrip();
        t_ext();
        t_nld();
        t_enable();
        finish_test();
    end
endmodule
bind bfs_top bfs_chk u_chk(.CLK_SYS_I, .SRST_I, .AVS_READ_I,
    .AVS_WRITE_I, .AVS_WAITREQUEST_O, .TRIP_INT_I, .EXTERNAL_TRIP_IN_I,
    .NOLOAD_INITIATE_IN_I, .SAMPLE_VALID_I, .FAILURE_OPERATE_OUT_O,
    .REISSUE_TRIP_OUT_O, .UNIT_ENABLED_O, .CURRENT_PRESENT_O);
`default_nettype wire
